// ### rtl/ectm_pkg.sv
package ectm_pkg;

   // ---------------------------------------------------------------
   // Register map (word indices on the plain port)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_TIMER  = 4'h0;
   localparam logic [3:0] ADDR_MODE   = 4'h1;
   localparam logic [3:0] ADDR_START  = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_MASK   = 4'h4;

   // ---------------------------------------------------------------
   // Mode register fields
   // ---------------------------------------------------------------
   localparam int MODE_OP_LSB   = 0;
   localparam int MODE_EDGE_LSB = 2;
   localparam int MODE_MEAS_BIT = 4;
   localparam int MODE_SRC_LSB  = 6;
   localparam int MODE_OVF_BIT  = 5;

   localparam logic [1:0] OP_TIMER   = 2'h0;
   localparam logic [1:0] OP_EVENT   = 2'h1;
   localparam logic [1:0] OP_MEASURE = 2'h2;

   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;

   // Status bit positions
   localparam int ST_UNDER = 0;
   localparam int ST_EDGE  = 1;
   localparam int ST_OVF   = 2;

   // Reset values and prescaler ratios
   localparam logic [15:0] TIMER_RST = 16'h0000;
   localparam logic [7:0]  MODE_RST  = 8'h00;
   localparam int DIV8_CYC  = 8;
   localparam int DIV32_CYC = 32;

   // Mode register content as carried between logic
   typedef struct packed {
      logic [1:0] src;
      logic       ovf;
      logic       meas_width;
      logic [1:0] edge_sel;
      logic [1:0] op;
   } ectm_mode_s;

endpackage : ectm_pkg

// ### rtl/ectm_sync.sv
`timescale 1ns/1ns
module ectm_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   // ---------------------------------------------------------------
   // Two flip-flop synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else if (ce) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : ectm_sync

// ### rtl/ectm_prescale.sv
`timescale 1ns/1ns
module ectm_prescale #(
   parameter int DIV = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   output logic      tick
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt_r;

   // ---------------------------------------------------------------
   // Free divider, one-cycle tick per period
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (ce) begin
         tick  <= (cnt_r == W'(DIV - 1));
         cnt_r <= (cnt_r == W'(DIV - 1)) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule : ectm_prescale

// ### rtl/ectm_timer.sv
`timescale 1ns/1ns
// How it works
// - Event mode counts input pin edges: rising, falling or both, by software.
// - Event mode counts down; underflow reloads, keeps counting, raises interrupt.
// - Value n gives one underflow per n plus one counted edges.
// - Counter runs only while the start flag is one.
// - Event mode timer read returns the live counter.
// - Stopped write in event mode loads reload register and counter.
// - Running write in event mode loads only reload; counter takes it at reload.
// - Measure mode counts prescaled clock up; edge captures count, restarts from zero.
// - Measure edge raises interrupt, except first edge after start.
// - Measure overflow raises interrupt and sets overflow flag same cycle.
// - Mode write while start flag is one clears overflow flag.
// - Measure mode timer read returns last captured result.
// - Result is undefined until second edge after start is captured.
// - Measure mode timer writes change neither counter nor reload.
// - Low two mode bits select timer, event counter or measure mode.
module ectm_timer
   import ectm_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [3:0]       addr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [WIDTH-1:0] rdata,
   input  wire logic             event_input_pin,
   input  wire logic             subclock_div32,
   output logic                  irq
);
   import ectm_pkg::*;

   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] reload_r;
   ectm_mode_s       mode_r;
   logic             start_r;
   logic [2:0]       status_r;
   logic [2:0]       mask_r;
   logic             pin_s;
   logic             pin_d_r;
   logic             sub_s;
   logic             sub_d_r;
   logic             seen_edge_r;
   logic             valid_r;
   logic             tick8;
   logic             tick32;
   logic             src_tick;
   logic             rise;
   logic             fall;
   logic             ev_edge;
   logic             ms_edge;
   logic             is_event;
   logic             is_meas;
   logic             run;
   logic             underflow;
   logic             overflow;
   logic             edge_irq;
   logic             wr_timer;
   logic             wr_mode;
   logic [2:0]       ev_set;

   // ---------------------------------------------------------------
   // Pin synchronisers and prescalers
   // ---------------------------------------------------------------
   ectm_sync u_pin_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   (event_input_pin),
      .q   (pin_s)
   );

   ectm_sync u_sub_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   (subclock_div32),
      .q   (sub_s)
   );

   ectm_prescale #(.DIV(DIV8_CYC)) u_div8 (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .tick (tick8)
   );

   ectm_prescale #(.DIV(DIV32_CYC)) u_div32 (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .tick (tick32)
   );

   // Edge history for pin and subclock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_d_r <= 1'b0;
         sub_d_r <= 1'b0;
      end else if (ce) begin
         pin_d_r <= pin_s;
         sub_d_r <= sub_s;
      end
   end

   // ---------------------------------------------------------------
   // Decode and edge qualification
   // ---------------------------------------------------------------
   assign rise     = pin_s & ~pin_d_r;
   assign fall     = ~pin_s & pin_d_r;
   assign is_event = (mode_r.op == OP_EVENT);
   assign is_meas  = (mode_r.op == OP_MEASURE);
   assign run      = start_r;
   assign wr_timer = wr & (addr == ADDR_TIMER);
   assign wr_mode  = wr & (addr == ADDR_MODE);

   // Counted edge in event mode
   always_comb begin
      case (mode_r.edge_sel)
         EDGE_FALL: ev_edge = fall;
         EDGE_RISE: ev_edge = rise;
         EDGE_BOTH: ev_edge = rise | fall;
         default:   ev_edge = 1'b0;
      endcase
   end

   // Measured edge: width uses both edges, period uses rise or fall by edge_sel[0]
   assign ms_edge = mode_r.meas_width ? (rise | fall)
                  : (mode_r.edge_sel[0] ? rise : fall);

   // Count source select for measure mode
   always_comb begin
      case (mode_r.src)
         2'h0:    src_tick = 1'b1;
         2'h1:    src_tick = tick8;
         2'h2:    src_tick = tick32;
         default: src_tick = sub_s & ~sub_d_r;
      endcase
   end

   assign underflow = ce & run & is_event & ev_edge & (cnt_r == '0);
   assign overflow  = ce & run & is_meas & ~ms_edge & src_tick
                    & (cnt_r == '1);
   assign edge_irq  = ce & run & is_meas & ms_edge & seen_edge_r;
   assign ev_set    = {overflow, edge_irq, underflow};

   // ---------------------------------------------------------------
   // Counter and reload register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r    <= TIMER_RST;
         reload_r <= TIMER_RST;
      end else if (ce) begin
         if (is_meas) begin
            // Writes ignored here
            if (run && ms_edge) begin
               reload_r <= cnt_r;
               cnt_r    <= '0;
            end else if (run && src_tick) begin
               cnt_r <= cnt_r + 1'b1;
            end
         end else begin
            if (wr_timer) begin
               reload_r <= wdata;
            end
            if (wr_timer && !run) begin
               cnt_r <= wdata;
            end else if (run && is_event && ev_edge) begin
               if (cnt_r == '0) begin
                  cnt_r <= wr_timer ? wdata : reload_r;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // First-edge tracking in measure mode
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seen_edge_r <= 1'b0;
         valid_r     <= 1'b0;
      end else if (ce) begin
         if (!run || !is_meas) begin
            seen_edge_r <= 1'b0;
            valid_r     <= 1'b0;
         end else if (ms_edge) begin
            seen_edge_r <= 1'b1;
            valid_r     <= seen_edge_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // Mode, start and mask registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_r  <= MODE_RST;
         start_r <= 1'b0;
         mask_r  <= 3'h0;
      end else if (ce) begin
         if (wr_mode) begin
            mode_r.op         <= wdata[MODE_OP_LSB +: 2];
            mode_r.edge_sel   <= wdata[MODE_EDGE_LSB +: 2];
            mode_r.meas_width <= wdata[MODE_MEAS_BIT];
            mode_r.src        <= wdata[MODE_SRC_LSB +: 2];
         end
         if (overflow) begin
            mode_r.ovf <= 1'b1;
         end else if (wr_mode && start_r) begin
            mode_r.ovf <= 1'b0;
         end
         if (wr && addr == ADDR_START) begin
            start_r <= wdata[0];
         end
         if (wr && addr == ADDR_MASK) begin
            mask_r <= wdata[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Sticky status, cleared by read; a set wins
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r <= 3'h0;
      end else if (ce) begin
         if (rd && addr == ADDR_STATUS) begin
            status_r <= ev_set;
         end else begin
            status_r <= status_r | ev_set;
         end
      end
   end

   assign irq = |(status_r & mask_r);

   // ---------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd) begin
            case (addr)
               ADDR_TIMER:  rdata <= is_meas ? reload_r : cnt_r;
               ADDR_MODE:   rdata <= WIDTH'(mode_r);
               ADDR_START:  rdata <= WIDTH'(start_r);
               ADDR_STATUS: rdata <= WIDTH'(status_r);
               ADDR_MASK:   rdata <= WIDTH'(mask_r);
               default:     rdata <= '0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_under;
      underflow;
   endsequence

   sequence s_meas_edge;
      ce && run && is_meas && ms_edge;
   endsequence

   chk_under_reload: assert property (@(posedge clk) disable iff (rst)
      s_under and !wr_timer |=> cnt_r == $past(reload_r))
      else $error("underflow did not reload");

   chk_under_status: assert property (@(posedge clk) disable iff (rst)
      s_under |=> status_r[ST_UNDER])
      else $error("underflow not flagged");

   chk_halt_hold: assert property (@(posedge clk) disable iff (rst)
      ce && !start_r && !wr_timer |=> $stable(cnt_r))
      else $error("counter moved while halted");

   chk_meas_capture: assert property (@(posedge clk) disable iff (rst)
      s_meas_edge |=> cnt_r == '0 && reload_r == $past(cnt_r))
      else $error("capture wrong");

   chk_first_edge: assert property (@(posedge clk) disable iff (rst)
      ce && run && is_meas && ms_edge && !seen_edge_r |=> !status_r[ST_EDGE]
         || $past(status_r[ST_EDGE]) && !$past(rd))
      else $error("first edge raised interrupt");

   chk_ovf_flag: assert property (@(posedge clk) disable iff (rst)
      overflow |=> mode_r.ovf && status_r[ST_OVF])
      else $error("overflow flag not set");

   chk_ovf_clear: assert property (@(posedge clk) disable iff (rst)
      ce && wr_mode && start_r && !overflow |=> !mode_r.ovf)
      else $error("overflow flag not cleared");

   chk_meas_nowrite: assert property (@(posedge clk) disable iff (rst)
      ce && is_meas && wr_timer && !(run && ms_edge) |=> $stable(reload_r))
      else $error("write changed reload in measure mode");

   chk_read_live: assert property (@(posedge clk) disable iff (rst)
      ce && rd && addr == ADDR_TIMER && is_event |=> rdata == $past(cnt_r))
      else $error("event read not live count");

   chk_stop_write: assert property (@(posedge clk) disable iff (rst)
      ce && !is_meas && !run && wr_timer
         |=> cnt_r == $past(wdata) && reload_r == $past(wdata))
      else $error("stopped write not loaded");

   chk_run_write: assert property (@(posedge clk) disable iff (rst)
      ce && is_event && run && wr_timer && !ev_edge
         |=> reload_r == $past(wdata) && $stable(cnt_r))
      else $error("running write touched counter");

   chk_meas_count: assert property (@(posedge clk) disable iff (rst)
      ce && run && is_meas && !ms_edge && src_tick
         |=> cnt_r == $past(cnt_r) + 1'b1)
      else $error("measure count did not step up");

   chk_meas_cnt_hold: assert property (@(posedge clk) disable iff (rst)
      ce && is_meas && wr_timer && !run |=> $stable(cnt_r))
      else $error("write changed counter in measure mode");

   chk_edge_status: assert property (@(posedge clk) disable iff (rst)
      edge_irq |=> status_r[ST_EDGE])
      else $error("measure edge not flagged");

   chk_valid_second: assert property (@(posedge clk) disable iff (rst)
      s_meas_edge and seen_edge_r |=> valid_r)
      else $error("result not valid after second edge");

endmodule : ectm_timer

// ### verif/ectm_pulse_src.sv
`timescale 1ns/1ns
// External pulse source on the event pin, plus a free-running slow clock
module ectm_pulse_src (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       kick,
   input  wire logic [7:0] n_tog,
   input  wire logic [7:0] half,
   output logic            pin,
   output logic            busy,
   output logic            sub
);
   logic [7:0] cnt_r;
   logic [7:0] tmr_r;
   logic [4:0] sdiv_r;

   // ----------------------------------------
   // Pin toggler
   // ----------------------------------------
   // Toggle the pin n_tog times, half cycles apart; pin holds its level after
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         tmr_r <= 8'h00;
         pin   <= 1'b0;
      end else if (kick) begin
         cnt_r <= n_tog;
         tmr_r <= half;
      end else if (cnt_r != 8'h00) begin
         if (tmr_r <= 8'h01) begin
            pin   <= ~pin;
            cnt_r <= cnt_r - 8'h01;
            tmr_r <= half;
         end else begin
            tmr_r <= tmr_r - 8'h01;
         end
      end
   end
   assign busy = (cnt_r != 8'h00);

   // ----------------------------------------
   // Slow clock
   // ----------------------------------------
   // One slow period per 32 fast cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdiv_r <= 5'h00;
      end else begin
         sdiv_r <= sdiv_r + 5'h01;
      end
   end
   assign sub = sdiv_r[4];
endmodule : ectm_pulse_src

// ### verif/tb_ectm_timer.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_ectm_timer;
   import ectm_pkg::*;
   logic        clk, rst, ce, wr, rd, kick, pin, busy, sub, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, rdata, v;
   logic [7:0]  n_tog, half;
   int          errors, checks_done, cyc;

   ectm_timer i_ectm_timer (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .event_input_pin(pin), .subclock_div32(sub),
      .irq(irq));
   ectm_pulse_src i_ectm_pulse_src (.clk(clk), .rst(rst), .kick(kick), .n_tog(n_tog),
      .half(half), .pin(pin), .busy(busy), .sub(sub));

   // ----------------------------------------
   // Clock, reset and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Read data lives in the cycle after the strobe only
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // Pin toggles, then room for the two-stage synchroniser
   task automatic toggle(input logic [7:0] n, input logic [7:0] h);
      @(posedge clk);
      kick <= 1'b1;
      n_tog <= n;
      half <= h;
      @(posedge clk);
      kick <= 1'b0;
      #1;
      for (int i = 0; i < 3000 && busy; i++) @(posedge clk);
      repeat (8) @(posedge clk);
      `CHK("src idle", 1'b0, busy)
   endtask : toggle

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd_reg(ADDR_TIMER, v);
      `CHK("timer rst", TIMER_RST, v)
      rd_reg(ADDR_MODE, v);
      `CHK("mode rst", {8'h00, MODE_RST}, v)
      rd_reg(4'h7, v);
      `CHK("unmapped", 16'h0000, v)
      $display("test reset done");
   endtask : t_reset

   // Seven toggles from low: four rises, three falls
   task automatic t_event();
      logic [1:0]  es [3]  = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
      logic [15:0] ec [3]  = '{16'h0003, 16'h0000, 16'h0000};
      logic [15:0] est [3] = '{16'h0001, 16'h0000, 16'h0001};
      for (int k = 0; k < 3; k++) begin
         wr_reg(ADDR_START, 16'h0000);
         wr_reg(ADDR_MODE, {12'h000, es[k], OP_EVENT});
         rd_reg(ADDR_STATUS, v);
         wr_reg(ADDR_TIMER, 16'h0003);
         rd_reg(ADDR_TIMER, v);
         `CHK("stopped write", 16'h0003, v)
         wr_reg(ADDR_MASK, 16'h0001);
         wr_reg(ADDR_START, 16'h0001);
         toggle(8'd7, 8'd4);
         `CHK("irq under", est[k][0], irq)
         rd_reg(ADDR_TIMER, v);
         `CHK("live count", ec[k], v)
         rd_reg(ADDR_STATUS, v);
         `CHK("underflow", est[k], v)
         `CHK("irq clear", 1'b0, irq)
         wr_reg(ADDR_START, 16'h0000);
         toggle(8'd1, 8'd4);
         rd_reg(ADDR_TIMER, v);
         `CHK("halted", ec[k], v)
      end
      $display("test event done");
   endtask : t_event

   task automatic t_reload();
      wr_reg(ADDR_MODE, {12'h000, EDGE_RISE, OP_EVENT});
      wr_reg(ADDR_TIMER, 16'h0001);
      wr_reg(ADDR_START, 16'h0001);
      wr_reg(ADDR_TIMER, 16'h0005);
      rd_reg(ADDR_TIMER, v);
      `CHK("running write", 16'h0001, v)
      toggle(8'd4, 8'd4);
      rd_reg(ADDR_TIMER, v);
      `CHK("new reload", 16'h0005, v)
      rd_reg(ADDR_STATUS, v);
      `CHK("underflow", 16'h0001, v)
      // Clock enable low: pin pulses and a stop write must leave no trace
      @(posedge clk);
      ce <= 1'b0;
      toggle(8'd2, 8'd4);
      wr_reg(ADDR_START, 16'h0000);
      ce <= 1'b1;
      rd_reg(ADDR_TIMER, v);
      `CHK("frozen count", 16'h0005, v)
      rd_reg(ADDR_START, v);
      `CHK("frozen start", 16'h0001, v)
      $display("test reload done");
   endtask : t_reload

   task automatic t_measure();
      logic [15:0] cap;
      logic [7:0]  hw [4] = '{8'd20, 8'd200, 8'd200, 8'd200};
      logic [15:0] lo [4] = '{16'd19, 16'd24, 16'd6, 16'd6};
      logic [15:0] hi [4] = '{16'd21, 16'd25, 16'd7, 16'd7};
      wr_reg(ADDR_START, 16'h0000);
      wr_reg(ADDR_MODE, 16'h0006);
      rd_reg(ADDR_STATUS, v);
      wr_reg(ADDR_MASK, 16'h0002);
      wr_reg(ADDR_START, 16'h0001);
      toggle(8'd1, 8'd20);
      rd_reg(ADDR_STATUS, v);
      `CHK("first edge", 16'h0000, v)
      toggle(8'd4, 8'd20);
      `CHK("edge irq", 1'b1, irq)
      rd_reg(ADDR_STATUS, v);
      `CHK("edge flag", 16'h0002, v)
      rd_reg(ADDR_TIMER, cap);
      `CHK("period", 1'b1, cap >= 16'd39 && cap <= 16'd41)
      wr_reg(ADDR_TIMER, 16'h0123);
      rd_reg(ADDR_TIMER, v);
      `CHK("meas write", cap, v)
      // Width in every count source: subclock, div32, div8, then div1 for overflow
      for (int s = 3; s >= 0; s--) begin
         wr_reg(ADDR_START, 16'h0000);
         wr_reg(ADDR_MODE, {8'h00, 2'(s), 6'h16});
         wr_reg(ADDR_START, 16'h0001);
         toggle(8'd3, hw[s]);
         rd_reg(ADDR_TIMER, v);
         `CHK("width", 1'b1, v >= lo[s] && v <= hi[s])
      end
      rd_reg(ADDR_STATUS, v);
      wr_reg(ADDR_MASK, 16'h0004);
      repeat (65600) @(posedge clk);
      `CHK("ovf irq", 1'b1, irq)
      rd_reg(ADDR_MODE, v);
      `CHK("ovf flag", 16'h0036, v)
      rd_reg(ADDR_STATUS, v);
      `CHK("ovf status", 16'h0004, v)
      wr_reg(ADDR_MODE, 16'h0016);
      rd_reg(ADDR_MODE, v);
      `CHK("ovf clear", 16'h0016, v)
      $display("test measure done");
   endtask : t_measure

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      kick = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      n_tog = 8'h00;
      half = 8'h01;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_event();
      t_reload();
      t_measure();
      give_verdict();
   end
endmodule : tb_ectm_timer
